// File: rtl/fsp_classify.sv
// Purpose: sort one word address into section and region
// Assumes: boot section occupies the top of flash up to the last word
// Notes: purely combinational; the caller registers what it needs

module fsp_classify #(
  parameter int AW = fsp_pkg::FLASH_AW,
  parameter int NO_READ_WHILE_WRITE_REGION_WORDS = fsp_pkg::NO_READ_WHILE_WRITE_REGION_WORDS
) (
  input wire logic [AW-1:0] addr,
  input wire logic [AW:0] boot_start,
  output logic in_boot,
  output logic in_no_read_while_write_region
);

  // ***************************************************************
  // boundaries
  // ***************************************************************
  // fixed split, one bit wider than the address to hold the full size
  localparam logic [AW:0] FLASH_TOP = (AW+1)'(2 ** AW);
  localparam logic [AW:0] NO_READ_WHILE_WRITE_REGION_START = FLASH_TOP - (AW+1)'(NO_READ_WHILE_WRITE_REGION_WORDS);

  logic [AW:0] addr_w;

  // widen once so both compares see the same width
  assign addr_w = {1'b0, addr};

  // section from fuses, region from the fixed split
  always_comb begin
    in_boot = (addr_w >= boot_start);
    in_no_read_while_write_region = (addr_w >= NO_READ_WHILE_WRITE_REGION_START);
  end

endmodule // fsp_classify

// File: rtl/fsp_pkg.sv
// Purpose: shared constants for the flash section protection block
// Assumes: word-addressed program flash, boot section at the top of flash
// Notes: lock pairs are {upper, lower}; a bit at 0 means programmed

package fsp_pkg;

  // ***************************************************************
  // flash geometry
  // ***************************************************************
  localparam int FLASH_AW = 14;
  localparam int FLASH_WORDS = 16384;
  localparam int NO_READ_WHILE_WRITE_REGION_WORDS = 2048;
  // boot section size in words per boot_size_fuses code
  localparam int BOOT_WORDS_F0 = 2048;
  localparam int BOOT_WORDS_F1 = 1024;
  localparam int BOOT_WORDS_F2 = 512;
  localparam int BOOT_WORDS_F3 = 256;

  // ***************************************************************
  // store-program operation codes on SPM_OP
  // ***************************************************************
  localparam logic [2:0] OP_BUF_LOAD = 3'h0;
  localparam logic [2:0] OP_PAGE_ERASE = 3'h1;
  localparam logic [2:0] OP_PAGE_WRITE = 3'h2;
  localparam logic [2:0] OP_LOCK_SET = 3'h3;
  localparam logic [2:0] OP_RWW_REEN = 3'h4;

  // ***************************************************************
  // lock pair fields
  // ***************************************************************
  localparam int LOCK_LOWER_BIT = 0;
  localparam int LOCK_UPPER_BIT = 1;
  localparam logic [1:0] LOCK_RESET = 2'h3;
  // positions of the two pairs inside a 4-bit lock data word
  localparam int LOCK_DATA_APP_LSB = 0;
  localparam int LOCK_DATA_BOOT_LSB = 2;

  // ***************************************************************
  // engine sequencing states
  // ***************************************************************
  typedef enum logic [0:0] {
    FSP_IDLE,
    FSP_BUSY
  } fsp_state_t;

endpackage

// File: rtl/fsp_top.sv
// Operation
// - store-program fetched from the application section is ignored
// - only boot-section store-program starts programming, any target
// - programming the rww region keeps the cpu running
// - programming the no_read_while_write_region region halts the cpu until done
// - boot section of every size lies inside the no_read_while_write_region region
// - rww busy flag reads one while rww region is blocked
// - boot size fuses set the split; each section own lock pair
// - locks programmed by software or programmer, restored by erase
// - general write lock does not block store-program
// - general read/write lock does not block loads or stores
// - application pair mode 1 leaves application section open
// - application pair mode 2 blocks writes to application section
// - application mode 3 blocks writes and boot loads of application
// - application mode 4 allows writes, blocks boot loads of application
// - application modes 3, 4 mask interrupts in application code when vectors are in boot
// - boot pair mode 1 leaves boot section open
// - boot pair mode 2 blocks writes to boot section
// - boot mode 3 blocks writes and application loads of boot
// - boot mode 4 allows writes, blocks application loads of boot
// - boot modes 3, 4 mask interrupts in boot code when vectors are in application
// - re-enable with store-program after completion clears rww busy
// - page buffer load with the engine idle clears rww busy
//
// Purpose: access policy for self-programming of on-chip program flash
// Assumes: cpu strobes are single-cycle and on SYS_CLK; fuses are static
// Notes: the page engine itself sits outside and reports ENGINE_DONE

module fsp_top #(
  parameter int AW = fsp_pkg::FLASH_AW,
  parameter int FLASH_WORDS = fsp_pkg::FLASH_WORDS,
  parameter int NO_READ_WHILE_WRITE_REGION_WORDS = fsp_pkg::NO_READ_WHILE_WRITE_REGION_WORDS,
  parameter int BOOT_WORDS_F0 = fsp_pkg::BOOT_WORDS_F0,
  parameter int BOOT_WORDS_F1 = fsp_pkg::BOOT_WORDS_F1,
  parameter int BOOT_WORDS_F2 = fsp_pkg::BOOT_WORDS_F2,
  parameter int BOOT_WORDS_F3 = fsp_pkg::BOOT_WORDS_F3
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [1:0] BOOT_SIZE_FUSES,
  input wire logic VECTORS_IN_BOOT,
  input wire logic [AW-1:0] FETCH_ADDR,
  input wire logic SPM_STROBE,
  input wire logic [2:0] SPM_OP,
  input wire logic [AW-1:0] SPM_ADDR,
  input wire logic [3:0] SPM_LOCK_DATA,
  input wire logic LPM_STROBE,
  input wire logic [AW-1:0] LPM_ADDR,
  input wire logic ENGINE_DONE,
  input wire logic ISP_LOCK_WR,
  input wire logic [3:0] ISP_LOCK_DATA,
  input wire logic CHIP_ERASE,
  output logic PROG_START,
  output logic PROG_ERASE,
  output logic [AW-1:0] PROG_ADDR,
  output logic BUF_LOAD,
  output logic SPM_IGNORED,
  output logic SPM_DENIED,
  output logic LPM_GRANT,
  output logic LPM_DENIED,
  output logic CPU_HALT,
  output logic ENGINE_BUSY,
  output logic RWW_BUSY_FLAG,
  output logic IRQ_DISABLE,
  output logic [1:0] APPLICATION_LOCK_PAIR,
  output logic [1:0] BOOTLOADER_LOCK_PAIR
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  // every boot size must fit inside the no_read_while_write_region region
  localparam bit BOOT_FITS = (BOOT_WORDS_F0 <= NO_READ_WHILE_WRITE_REGION_WORDS) &&
    (BOOT_WORDS_F1 <= NO_READ_WHILE_WRITE_REGION_WORDS) && (BOOT_WORDS_F2 <= NO_READ_WHILE_WRITE_REGION_WORDS) &&
    (BOOT_WORDS_F3 <= NO_READ_WHILE_WRITE_REGION_WORDS);
  localparam bit BOOT_NONZERO = (BOOT_WORDS_F0 > 0) &&
    (BOOT_WORDS_F1 > 0) && (BOOT_WORDS_F2 > 0) && (BOOT_WORDS_F3 > 0);

  generate
    if (FLASH_WORDS != 2 ** AW) begin : g_bad_size
      $error("flash size must equal two to the address width");
    end
    if (NO_READ_WHILE_WRITE_REGION_WORDS <= 0 || NO_READ_WHILE_WRITE_REGION_WORDS >= FLASH_WORDS) begin : g_bad_no_read_while_write_region
      $error("no_read_while_write_region region must be smaller than flash");
    end
    if (!BOOT_FITS || !BOOT_NONZERO) begin : g_bad_boot
      $error("boot section sizes must lie within the no_read_while_write_region region");
    end
  endgenerate

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    fsp_pkg::fsp_state_t state;
    logic halt;
    logic rww_busy;
    logic [1:0] app_lock;
    logic [1:0] boot_lock;
    logic prog_start;
    logic prog_erase;
    logic [AW-1:0] prog_addr;
    logic buf_load;
    logic spm_ignored;
    logic spm_denied;
    logic lpm_grant;
    logic lpm_denied;
    logic irq_disable;
  } fsp_regs_t;

  fsp_regs_t q;
  fsp_regs_t d;

  // ***************************************************************
  // lock pair decode
  // ***************************************************************
  // lower bit programmed means modes 2 and 3: writes refused
  function automatic logic wr_blocked(input logic [1:0] pair);
    wr_blocked = ~pair[fsp_pkg::LOCK_LOWER_BIT];
  endfunction

  // upper bit programmed means modes 3 and 4: cross-section loads refused
  function automatic logic rd_blocked(input logic [1:0] pair);
    rd_blocked = ~pair[fsp_pkg::LOCK_UPPER_BIT];
  endfunction

  // boot size in words from the fuse code
  function automatic logic [AW:0] boot_words(input logic [1:0] fuses);
    case (fuses)
      2'h0: boot_words = (AW+1)'(BOOT_WORDS_F0);
      2'h1: boot_words = (AW+1)'(BOOT_WORDS_F1);
      2'h2: boot_words = (AW+1)'(BOOT_WORDS_F2);
      default: boot_words = (AW+1)'(BOOT_WORDS_F3);
    endcase
  endfunction

  // ***************************************************************
  // address classification
  // ***************************************************************
  localparam logic [AW:0] FLASH_TOP = (AW+1)'(FLASH_WORDS);

  logic [AW:0] boot_start;
  logic [AW-1:0] cls_addr [3];
  logic [2:0] cls_boot;
  logic [2:0] cls_no_read_while_write_region;

  // fuses move the section split, the region split is fixed
  assign boot_start = FLASH_TOP - boot_words(BOOT_SIZE_FUSES);
  assign cls_addr[0] = FETCH_ADDR;
  assign cls_addr[1] = SPM_ADDR;
  assign cls_addr[2] = LPM_ADDR;

  // one classifier each for fetch, store target and load target
  generate
    for (genvar i = 0; i < 3; i++) begin : g_cls
      fsp_classify #(
        .AW(AW),
        .NO_READ_WHILE_WRITE_REGION_WORDS(NO_READ_WHILE_WRITE_REGION_WORDS)
      ) u_cls (
        .addr(cls_addr[i]),
        .boot_start(boot_start),
        .in_boot(cls_boot[i]),
        .in_no_read_while_write_region(cls_no_read_while_write_region[i])
      );
    end
  endgenerate

  // ***************************************************************
  // decision terms
  // ***************************************************************
  logic fetch_boot;
  logic spm_tgt_boot;
  logic spm_tgt_no_read_while_write_region;
  logic lpm_tgt_boot;
  logic tgt_wr_blocked;
  logic lpm_cross_blocked;
  logic lpm_rww_blocked;
  logic is_page_op;
  logic engine_idle;

  // the general memory lock has no say in any of these terms
  always_comb begin
    fetch_boot = cls_boot[0];
    spm_tgt_boot = cls_boot[1];
    spm_tgt_no_read_while_write_region = cls_no_read_while_write_region[1];
    lpm_tgt_boot = cls_boot[2];
    engine_idle = (q.state == fsp_pkg::FSP_IDLE);
    is_page_op = (SPM_OP == fsp_pkg::OP_PAGE_ERASE) ||
      (SPM_OP == fsp_pkg::OP_PAGE_WRITE);
    // write permission follows the pair of the target section
    tgt_wr_blocked = spm_tgt_boot ? wr_blocked(q.boot_lock)
                                  : wr_blocked(q.app_lock);
    // loads only cross-checked: boot into application, application into boot
    lpm_cross_blocked =
      (fetch_boot && !lpm_tgt_boot && rd_blocked(q.app_lock)) ||
      (!fetch_boot && lpm_tgt_boot && rd_blocked(q.boot_lock));
    // loads into a blocked rww region are refused rather than undefined
    lpm_rww_blocked = q.rww_busy && !cls_no_read_while_write_region[2];
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    d = q;
    d.prog_start = 1'b0;
    d.buf_load = 1'b0;
    d.spm_ignored = 1'b0;
    d.spm_denied = 1'b0;
    d.lpm_grant = 1'b0;
    d.lpm_denied = 1'b0;

    // engine completion ends the halt; rww busy stays until cleared
    if (q.state == fsp_pkg::FSP_BUSY && ENGINE_DONE) begin
      d.state = fsp_pkg::FSP_IDLE;
      d.halt = 1'b0;
    end

    // store-program decisions
    if (SPM_STROBE) begin
      if (!fetch_boot) begin
        d.spm_ignored = 1'b1;
      end else begin
        case (SPM_OP)
          fsp_pkg::OP_BUF_LOAD: begin
            if (engine_idle) begin
              d.buf_load = 1'b1;
              d.rww_busy = 1'b0;
            end else begin
              d.spm_ignored = 1'b1;
            end
          end
          fsp_pkg::OP_PAGE_ERASE,
          fsp_pkg::OP_PAGE_WRITE: begin
            if (!engine_idle) begin
              d.spm_ignored = 1'b1;
            end else if (is_page_op && tgt_wr_blocked) begin
              d.spm_denied = 1'b1;
            end else begin
              // modes 1 and 4 of either pair let the page op through
              d.prog_start = 1'b1;
              d.prog_erase = (SPM_OP == fsp_pkg::OP_PAGE_ERASE);
              d.prog_addr = SPM_ADDR;
              d.state = fsp_pkg::FSP_BUSY;
              d.halt = spm_tgt_no_read_while_write_region;
              // rww target: cpu runs on, rww reads blocked
              if (!spm_tgt_no_read_while_write_region) begin
                d.rww_busy = 1'b1;
              end
            end
          end
          fsp_pkg::OP_LOCK_SET: begin
            // software may only program bits, never restore them
            d.app_lock = q.app_lock &
              SPM_LOCK_DATA[fsp_pkg::LOCK_DATA_APP_LSB +: 2];
            d.boot_lock = q.boot_lock &
              SPM_LOCK_DATA[fsp_pkg::LOCK_DATA_BOOT_LSB +: 2];
          end
          fsp_pkg::OP_RWW_REEN: begin
            // refused while the engine still works on a page
            if (engine_idle) begin
              d.rww_busy = 1'b0;
            end else begin
              d.spm_ignored = 1'b1;
            end
          end
          default: begin
            d.spm_ignored = 1'b1;
          end
        endcase
      end
    end

    // chip erase overrides software lock writes; programmer writes combine with them
    if (CHIP_ERASE) begin
      d.app_lock = fsp_pkg::LOCK_RESET;
      d.boot_lock = fsp_pkg::LOCK_RESET;
    end else if (ISP_LOCK_WR) begin
      d.app_lock = d.app_lock &
        ISP_LOCK_DATA[fsp_pkg::LOCK_DATA_APP_LSB +: 2];
      d.boot_lock = d.boot_lock &
        ISP_LOCK_DATA[fsp_pkg::LOCK_DATA_BOOT_LSB +: 2];
    end

    // program loads: own-section reads pass unless they target a blocked rww region
    if (LPM_STROBE) begin
      if (lpm_cross_blocked || lpm_rww_blocked) begin
        d.lpm_denied = 1'b1;
      end else begin
        d.lpm_grant = 1'b1;
      end
    end

    // interrupt masking follows the fetch section and vector placement
    d.irq_disable =
      (!fetch_boot && VECTORS_IN_BOOT && rd_blocked(q.app_lock)) ||
      (fetch_boot && !VECTORS_IN_BOOT && rd_blocked(q.boot_lock));
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  // locks come up unprogrammed; a real part would load them from storage
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      q.state <= fsp_pkg::FSP_IDLE;
      q.halt <= 1'b0;
      q.rww_busy <= 1'b0;
      q.app_lock <= fsp_pkg::LOCK_RESET;
      q.boot_lock <= fsp_pkg::LOCK_RESET;
      q.prog_start <= 1'b0;
      q.prog_erase <= 1'b0;
      q.prog_addr <= '0;
      q.buf_load <= 1'b0;
      q.spm_ignored <= 1'b0;
      q.spm_denied <= 1'b0;
      q.lpm_grant <= 1'b0;
      q.lpm_denied <= 1'b0;
      q.irq_disable <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // all straight from the state register
  assign PROG_START = q.prog_start;
  assign PROG_ERASE = q.prog_erase;
  assign PROG_ADDR = q.prog_addr;
  assign BUF_LOAD = q.buf_load;
  assign SPM_IGNORED = q.spm_ignored;
  assign SPM_DENIED = q.spm_denied;
  assign LPM_GRANT = q.lpm_grant;
  assign LPM_DENIED = q.lpm_denied;
  assign CPU_HALT = q.halt;
  assign ENGINE_BUSY = (q.state == fsp_pkg::FSP_BUSY);
  assign RWW_BUSY_FLAG = q.rww_busy;
  assign IRQ_DISABLE = q.irq_disable;
  assign APPLICATION_LOCK_PAIR = q.app_lock;
  assign BOOTLOADER_LOCK_PAIR = q.boot_lock;

endmodule // fsp_top

// File: testbench/fsp_asserts.sv
// Purpose: port-level checks of the flash section protection block
// Assumes: one clock domain, strobes one cycle wide
// Notes: bound into fsp_top after the module
module fsp_checker #(
  parameter int AW = fsp_pkg::FLASH_AW,
  parameter int FLASH_WORDS = fsp_pkg::FLASH_WORDS,
  parameter int NO_READ_WHILE_WRITE_REGION_WORDS = fsp_pkg::NO_READ_WHILE_WRITE_REGION_WORDS,
  parameter int BOOT_WORDS_F0 = fsp_pkg::BOOT_WORDS_F0,
  parameter int BOOT_WORDS_F1 = fsp_pkg::BOOT_WORDS_F1,
  parameter int BOOT_WORDS_F2 = fsp_pkg::BOOT_WORDS_F2,
  parameter int BOOT_WORDS_F3 = fsp_pkg::BOOT_WORDS_F3
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [1:0] BOOT_SIZE_FUSES,
  input wire logic VECTORS_IN_BOOT,
  input wire logic [AW-1:0] FETCH_ADDR,
  input wire logic SPM_STROBE,
  input wire logic [2:0] SPM_OP,
  input wire logic [AW-1:0] SPM_ADDR,
  input wire logic LPM_STROBE,
  input wire logic [AW-1:0] LPM_ADDR,
  input wire logic ENGINE_DONE,
  input wire logic CHIP_ERASE,
  input wire logic PROG_START,
  input wire logic BUF_LOAD,
  input wire logic SPM_IGNORED,
  input wire logic SPM_DENIED,
  input wire logic LPM_GRANT,
  input wire logic LPM_DENIED,
  input wire logic CPU_HALT,
  input wire logic ENGINE_BUSY,
  input wire logic RWW_BUSY_FLAG,
  input wire logic IRQ_DISABLE,
  input wire logic [1:0] APPLICATION_LOCK_PAIR,
  input wire logic [1:0] BOOTLOADER_LOCK_PAIR
);
  timeunit 1ns;
  timeprecision 1ns;
  int bw;
  logic fb, tb, tn, lb, ok, pg, cl, ie;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // boot size from the fuse code
  always_comb begin
    bw = BOOT_WORDS_F3;
    case (BOOT_SIZE_FUSES)
      2'h0: bw = BOOT_WORDS_F0;
      2'h1: bw = BOOT_WORDS_F1;
      2'h2: bw = BOOT_WORDS_F2;
      default: bw = BOOT_WORDS_F3;
    endcase
  end
  // section of fetch and targets, and the lock verdicts
  assign fb = int'(FETCH_ADDR) >= FLASH_WORDS - bw;
  assign tb = int'(SPM_ADDR) >= FLASH_WORDS - bw;
  assign lb = int'(LPM_ADDR) >= FLASH_WORDS - bw;
  assign tn = int'(SPM_ADDR) >= FLASH_WORDS - NO_READ_WHILE_WRITE_REGION_WORDS;
  assign ok = tb ? BOOTLOADER_LOCK_PAIR[0] : APPLICATION_LOCK_PAIR[0];
  assign pg = SPM_STROBE & fb & !ENGINE_BUSY &
    (SPM_OP == fsp_pkg::OP_PAGE_ERASE | SPM_OP == fsp_pkg::OP_PAGE_WRITE);
  assign cl = (fb & !lb & !APPLICATION_LOCK_PAIR[1]) |
    (!fb & lb & !BOOTLOADER_LOCK_PAIR[1]);
  assign ie = (!fb & VECTORS_IN_BOOT & !APPLICATION_LOCK_PAIR[1]) |
    (fb & !VECTORS_IN_BOOT & !BOOTLOADER_LOCK_PAIR[1]);
  // ************************************************************
  // assertions
  // ************************************************************
  a_app_spm_ignored: assert property (
    SPM_STROBE & !fb |=> SPM_IGNORED & !PROG_START & !BUF_LOAD)
    else $error("store from application section not ignored");
  a_page_start_ok: assert property (
    pg & ok |=> PROG_START & (CPU_HALT == $past(tn)))
    else $error("page op start or halt wrong");
  a_rww_busy_set: assert property (
    pg & ok & !tn |=> RWW_BUSY_FLAG & !CPU_HALT)
    else $error("rww page op did not mark busy");
  a_page_denied: assert property (
    pg & !ok |=> SPM_DENIED & !PROG_START)
    else $error("locked page op not denied");
  a_halt_held: assert property (
    CPU_HALT & !ENGINE_DONE |=> CPU_HALT)
    else $error("halt dropped before done");
  a_halt_release: assert property (
    ENGINE_BUSY & ENGINE_DONE |=> !ENGINE_BUSY & !CPU_HALT)
    else $error("busy or halt kept after done");
  a_rww_cleared: assert property (
    SPM_STROBE & fb & !ENGINE_BUSY & (SPM_OP == fsp_pkg::OP_BUF_LOAD |
    SPM_OP == fsp_pkg::OP_RWW_REEN) |=> !RWW_BUSY_FLAG)
    else $error("rww busy not cleared");
  a_lpm_cross: assert property (
    LPM_STROBE & cl |=> LPM_DENIED & !LPM_GRANT)
    else $error("cross-section load not denied");
  a_lpm_open: assert property (
    LPM_STROBE & !cl & !RWW_BUSY_FLAG |=> LPM_GRANT & !LPM_DENIED)
    else $error("open load not granted");
  a_irq_mask: assert property (
    1'b1 |=> IRQ_DISABLE == $past(ie))
    else $error("interrupt disable wrong");
  a_lock_erase: assert property (
    CHIP_ERASE |=> APPLICATION_LOCK_PAIR == 2'h3 &&
    BOOTLOADER_LOCK_PAIR == 2'h3)
    else $error("chip erase did not restore locks");
  a_lock_oneway: assert property (
    !CHIP_ERASE |=> (APPLICATION_LOCK_PAIR &
    ~$past(APPLICATION_LOCK_PAIR)) == 2'h0 && (BOOTLOADER_LOCK_PAIR &
    ~$past(BOOTLOADER_LOCK_PAIR)) == 2'h0)
    else $error("lock bit returned to one without erase");
  c_no_read_while_write_region_op: cover property (pg & ok & tn);
  c_cross_load: cover property (LPM_STROBE & cl);
  c_irq_masked: cover property (IRQ_DISABLE);
endmodule // fsp_checker

bind fsp_top fsp_checker #(.AW(AW), .FLASH_WORDS(FLASH_WORDS),
  .NO_READ_WHILE_WRITE_REGION_WORDS(NO_READ_WHILE_WRITE_REGION_WORDS), .BOOT_WORDS_F0(BOOT_WORDS_F0),
  .BOOT_WORDS_F1(BOOT_WORDS_F1), .BOOT_WORDS_F2(BOOT_WORDS_F2),
  .BOOT_WORDS_F3(BOOT_WORDS_F3)) u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
  .BOOT_SIZE_FUSES(BOOT_SIZE_FUSES), .VECTORS_IN_BOOT(VECTORS_IN_BOOT),
  .FETCH_ADDR(FETCH_ADDR), .SPM_STROBE(SPM_STROBE), .SPM_OP(SPM_OP),
  .SPM_ADDR(SPM_ADDR), .LPM_STROBE(LPM_STROBE), .LPM_ADDR(LPM_ADDR),
  .ENGINE_DONE(ENGINE_DONE), .CHIP_ERASE(CHIP_ERASE),
  .PROG_START(PROG_START), .BUF_LOAD(BUF_LOAD), .SPM_IGNORED(SPM_IGNORED),
  .SPM_DENIED(SPM_DENIED), .LPM_GRANT(LPM_GRANT), .LPM_DENIED(LPM_DENIED),
  .CPU_HALT(CPU_HALT), .ENGINE_BUSY(ENGINE_BUSY),
  .RWW_BUSY_FLAG(RWW_BUSY_FLAG), .IRQ_DISABLE(IRQ_DISABLE),
  .APPLICATION_LOCK_PAIR(APPLICATION_LOCK_PAIR),
  .BOOTLOADER_LOCK_PAIR(BOOTLOADER_LOCK_PAIR));

// File: testbench/fsp_engine_model.sv
// Purpose: page engine answering accepted page ops after a delay
// Assumes: start is a one-cycle pulse
// Notes: delay 0 answers promptly, larger values stall the cpu longer
module fsp_engine_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] delay,
  output logic done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // countdown; done is a single-cycle pulse, never held
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      done <= 1'b0;
    end else begin
      done <= (cnt == 1);
      if (start) cnt <= int'(delay) + 1;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule // fsp_engine_model

// File: testbench/testbench.sv
// Purpose: self-checking bench for fsp_top
// Assumes: default geometry; fuse code 3 puts boot start at word 3F00
// Notes: the bench plays the cpu and the programmer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, vib = 1'b0, ss = 1'b0, ls = 1'b0;
  logic iw = 1'b0, ce = 1'b0, done;
  logic [1:0] fuse = 2'h0, apl, bpl;
  logic [2:0] sop = 3'h0;
  logic [13:0] fa = 14'h0000, sa = 14'h0000, la = 14'h0000, pa;
  logic [3:0] sld = 4'hF, idt = 4'hF;
  logic [7:0] dly = 8'h00;
  logic ps, pe, bl, si, sd, lg, ldn, ch, eb, rb, irq;
  int error_cnt = 0, checks = 0, cyc = 0;
  fsp_top DUT (.SYS_CLK(clk), .RSTN(rstn), .BOOT_SIZE_FUSES(fuse),
    .VECTORS_IN_BOOT(vib), .FETCH_ADDR(fa), .SPM_STROBE(ss), .SPM_OP(sop),
    .SPM_ADDR(sa), .SPM_LOCK_DATA(sld), .LPM_STROBE(ls), .LPM_ADDR(la),
    .ENGINE_DONE(done), .ISP_LOCK_WR(iw), .ISP_LOCK_DATA(idt),
    .CHIP_ERASE(ce), .PROG_START(ps), .PROG_ERASE(pe), .PROG_ADDR(pa),
    .BUF_LOAD(bl), .SPM_IGNORED(si), .SPM_DENIED(sd), .LPM_GRANT(lg),
    .LPM_DENIED(ldn), .CPU_HALT(ch), .ENGINE_BUSY(eb),
    .RWW_BUSY_FLAG(rb), .IRQ_DISABLE(irq), .APPLICATION_LOCK_PAIR(apl),
    .BOOTLOADER_LOCK_PAIR(bpl));
  fsp_engine_model eng (.clk(clk), .rstn(rstn), .start(ps), .delay(dly),
    .done(done));
  // ************************************************************
  // clock, watchdog and shared tasks
  // ************************************************************
  always #5 clk = ~clk;
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one store-program strobe; answer is visible on return
  task automatic store_program_instruction(input logic [13:0] f, input logic [2:0] op,
    input logic [13:0] a, input logic [3:0] d);
    @(posedge clk);
    ss <= 1'b1;
    fa <= f;
    sop <= op;
    sa <= a;
    sld <= d;
    @(posedge clk);
    ss <= 1'b0;
    #1;
  endtask
  task automatic lpm(input logic [13:0] f, input logic [13:0] a);
    @(posedge clk);
    ls <= 1'b1;
    fa <= f;
    la <= a;
    @(posedge clk);
    ls <= 1'b0;
    #1;
  endtask
  task automatic wait_idle();
    // look just after each edge, never in the edge's own time step
    for (int i = 0; i < 300 && eb !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk({eb, ch}, 2'h0);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  // each fuse code: boot start edge, and boot writing its own pages
  task automatic t_fuses();
    logic [13:0] bs [4] = '{14'h3800, 14'h3C00, 14'h3E00, 14'h3F00};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fuse <= 2'(i);
      store_program_instruction(bs[i], fsp_pkg::OP_BUF_LOAD, 14'h0000, 4'hF);
      chk(bl, 1'b1);
      store_program_instruction(bs[i] - 14'h0001, fsp_pkg::OP_PAGE_WRITE, bs[i], 4'hF);
      chk({si, ps}, 2'h2);
      store_program_instruction(bs[i], fsp_pkg::OP_PAGE_WRITE, bs[i], 4'hF);
      chk({ps, ch, pa}, {2'h3, bs[i]});
      wait_idle();
    end
  endtask
  // slow rww erase: no_read_while_write_region readable, rww blocked until re-enabled
  task automatic t_rww();
    @(posedge clk);
    dly <= 8'h28;
    store_program_instruction(14'h3F00, fsp_pkg::OP_PAGE_ERASE, 14'h0040, 4'hF);
    chk({ps, pe, ch, rb, eb, pa}, {5'h1B, 14'h0040});
    lpm(14'h3F00, 14'h0010);
    chk(ldn, 1'b1);
    lpm(14'h3F00, 14'h3800);
    chk(lg, 1'b1);
    store_program_instruction(14'h3F00, fsp_pkg::OP_RWW_REEN, 14'h0000, 4'hF);
    chk({si, rb}, 2'h3);
    wait_idle();
    chk(rb, 1'b1);
    store_program_instruction(14'h3F00, fsp_pkg::OP_RWW_REEN, 14'h0000, 4'hF);
    chk(rb, 1'b0);
    lpm(14'h3F00, 14'h0010);
    chk(lg, 1'b1);
    store_program_instruction(14'h3F00, fsp_pkg::OP_PAGE_WRITE, 14'h0080, 4'hF);
    chk({pe, rb}, 2'h1);
    wait_idle();
    store_program_instruction(14'h3F00, fsp_pkg::OP_BUF_LOAD, 14'h0000, 4'hF);
    chk({bl, rb}, 2'h2);
    store_program_instruction(14'h3F00, 3'h7, 14'h0000, 4'hF);
    chk({si, ps, bl}, 3'h4);
  endtask
  // all four modes of one lock pair: writes, cross loads, interrupts
  task automatic t_pair(input bit bsel);
    logic [1:0] md [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
    logic [13:0] own, oth;
    own = bsel ? 14'h3F80 : 14'h3800;
    oth = bsel ? 14'h0000 : 14'h3F00;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      ce <= 1'b0;
      #1;
      chk({apl, bpl}, 4'hF);
      if (bsel) begin
        @(posedge clk);
        iw <= 1'b1;
        idt <= {md[m], 2'h3};
        @(posedge clk);
        iw <= 1'b0;
        #1;
      end else store_program_instruction(14'h3F00, fsp_pkg::OP_LOCK_SET, 14'h0000, {2'h3, md[m]});
      chk({bsel ? bpl : apl, bsel ? apl : bpl}, {md[m], 2'h3});
      store_program_instruction(14'h3F00, fsp_pkg::OP_PAGE_WRITE, own, 4'hF);
      chk({ps, sd}, {md[m][0], !md[m][0]});
      wait_idle();
      lpm(oth, own);
      chk({lg, ldn}, {md[m][1], !md[m][1]});
      @(posedge clk);
      vib <= !bsel;
      fa <= own;
      repeat (2) @(posedge clk);
      #1;
      chk(irq, !md[m][1]);
    end
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({apl, bpl, rb, ch, irq}, 7'h78);
    t_fuses();
    t_rww();
    t_pair(1'b0);
    t_pair(1'b1);
    results();
  end
endmodule // testbench
